// ---- src/fcd_pkg.sv ----
// Package of constants, types and field layouts for the config decoder
package fcd_pkg;

  // Analog configuration word field positions
  localparam int ASENS_LSB   = 0;
  localparam int ASENS_W     = 6;
  localparam int AMODE_LSB   = 7;
  localparam int AMODE_W     = 3;
  localparam int AFILT_LSB   = 11;
  localparam int AFILT_W     = 2;
  // Digital configuration word field positions
  localparam int DMODE_LSB   = 0;
  localparam int DMODE_W     = 2;
  localparam int DSCAN_LSB   = 3;
  localparam int DSCAN_W     = 4;

  // Reset value of both configuration words (channel off)
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Sensor code boundaries
  localparam logic [5:0] SENS_OFF      = 6'h00;
  localparam logic [5:0] SENS_MV1      = 6'h01;
  localparam logic [5:0] SENS_MV2      = 6'h02;
  localparam logic [5:0] SENS_OHM      = 6'h03;
  localparam logic [5:0] SENS_TC_LO    = 6'h04;
  localparam logic [5:0] SENS_TC_HI    = 6'h12;
  localparam logic [5:0] SENS_RTD_LO   = 6'h13;
  localparam logic [5:0] SENS_RTD_HI   = 6'h1d;
  localparam logic [5:0] SENS_COMP     = 6'h1e;

  // Coded burnout special values
  localparam logic [15:0] CODE_UNDER   = 16'h7d00;
  localparam logic [15:0] CODE_OVER    = 16'h7d01;
  localparam logic [15:0] CODE_BO_SENS = 16'h7d02;
  localparam logic [15:0] CODE_BO_COMP = 16'h7d03;

  // Mode bit meanings
  localparam int CJ_FIXED_BIT = 2;
  localparam logic [1:0] BO_NONE  = 2'h0;
  localparam logic [1:0] BO_DOWN  = 2'h1;
  localparam logic [1:0] BO_UP    = 2'h2;
  localparam logic [1:0] BO_CODED = 2'h3;
  localparam logic [2:0] WIRE4_MODE = 3'h1;

  // Digital mode codes
  localparam logic [1:0] DM_OFF    = 2'h0;
  localparam logic [1:0] DM_ACT    = 2'h1;
  localparam logic [1:0] DM_OFF2   = 2'h2;
  localparam logic [1:0] DM_ACT_LF = 2'h3;

  // Timing
  localparam int CLK_HZ       = 25_000_000;
  localparam int TICK_US      = 500;
  localparam int TICK_CYC     = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int CNT_W        = 16;
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(TICK_CYC - 1);
  localparam logic [6:0] DISABLED_TICKS = 7'h01;

  // Sensor classes
  typedef enum logic [2:0] {
    CLS_OFF, CLS_MV, CLS_OHM, CLS_TC, CLS_RTD, CLS_COMP
  } fcd_class_t;

  // Decoded analog settings
  typedef struct packed {
    fcd_class_t  sensClass;  // Sensor class
    logic [5:0]  sensCode;   // Sensor type code
    logic        cjFixed;    // Fixed cold-junction reference
    logic [1:0]  burnout;    // Burnout handling
    logic        wire4;      // Four-wire measurement
    logic [3:0]  avgDepth;   // Readings averaged, 1/2/4/8
  } fcd_analog_t;

  // Decoded digital settings
  typedef struct packed {
    logic        active;     // Channel active
    logic        lineFault;  // Line-fault detection on
    logic [6:0]  powerTicks; // Power-up time in 500 us ticks
  } fcd_digital_t;

  // Raw acquisition status from the converter side
  typedef struct packed {
    logic        valid;      // Reading strobe
    logic [15:0] value;      // Converted value
    logic        under;      // Under range
    logic        over;       // Over range
    logic        boSens;     // Sensor burnout
    logic        boComp;     // Compensator burnout
  } fcd_sample_t;

  // Scan code to power-up time in 500 us ticks (ms times two)
  function automatic logic [6:0] scan_ticks(input logic [3:0] code);
    case (code)
      4'h0: scan_ticks = 7'h02;
      4'h1: scan_ticks = 7'h04;
      4'h2: scan_ticks = 7'h06;
      4'h3: scan_ticks = 7'h08;
      4'h4: scan_ticks = 7'h0a;
      4'h5: scan_ticks = 7'h0c;
      4'h6: scan_ticks = 7'h10;
      4'h7: scan_ticks = 7'h14;
      4'h8: scan_ticks = 7'h18;
      4'h9: scan_ticks = 7'h1c;
      4'ha: scan_ticks = 7'h20;
      4'hb: scan_ticks = 7'h24;
      4'hc: scan_ticks = 7'h28;
      4'hd: scan_ticks = 7'h32;
      4'he: scan_ticks = 7'h3c;
      default: scan_ticks = 7'h46;
    endcase
  endfunction

endpackage

// ---- src/fcd_tick_div.sv ----
// Divider that makes the 500 us tick enable
`timescale 1ns/100ps
module fcd_tick_div
  import fcd_pkg::*;
(
  input  wire logic clk_sys, // System clock
  input  wire logic rst,     // Synchronous reset
  input  wire logic clr,     // Restart the interval
  output logic      tick     // One-cycle pulse every 500 us
);
  // Whole state in one struct
  typedef struct packed {
    logic [CNT_W-1:0] cnt;   // Cycle counter
    logic             tick;  // Tick pulse
  } fcd_div_t;

  fcd_div_t s_r;             // Registered state
  fcd_div_t s_nxt;           // Next state

  // Count cycles, pulse on wrap
  always_comb begin
    s_nxt      = s_r;
    s_nxt.tick = 1'b0;
    if (clr) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == TICK_LAST) begin
      s_nxt.cnt  = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;
endmodule

// ---- src/fcd_channel_decoder.sv ----
// Channel configuration decoder: analog result shaping and digital scan slot
`timescale 1ns/100ps
module fcd_channel_decoder
  import fcd_pkg::*;
(
  input  wire logic        clk_sys,      // System clock
  input  wire logic        rst,          // Synchronous reset
  input  wire logic        cfgWrA,       // Write analog config word
  input  wire logic        cfgWrD,       // Write digital config word
  input  wire logic [15:0] cfgWdata,     // Config word from command
  input  wire logic [15:0] cjRefTenths,  // Fixed CJ reference, 0.1 C
  input  wire logic [15:0] cjAutoTenths, // Measured CJ temperature
  input  wire logic [15:0] rangeLo,      // Lower range limit
  input  wire logic [15:0] rangeHi,      // Upper range limit
  input  wire fcd_sample_t sampleIn,     // Converter reading
  input  wire logic [15:0] digInputs,    // Acquired digital data
  input  wire logic        scanStart,    // Start a digital scan slot
  output logic [15:0]      cfgRdA,       // Analog config readback
  output logic [15:0]      cfgRdD,       // Digital config readback
  output fcd_analog_t      analogCfg,    // Decoded analog settings
  output fcd_digital_t     digitalCfg,   // Decoded digital settings
  output logic [15:0]      cjUsedTenths, // CJ temperature in use
  output logic [15:0]      analogData,   // Shaped analog result
  output logic             analogValid,  // Result strobe
  output logic             chanPower,    // Digital channel powered
  output logic             acquire,      // Acquisition pulse
  output logic [15:0]      digitalData   // Digital channel data
);

  // Whole module state
  typedef struct packed {
    logic [15:0]  cfgA;      // Analog config word
    logic [15:0]  cfgD;      // Digital config word
    fcd_analog_t  ana;       // Decoded analog
    fcd_digital_t dig;       // Decoded digital
    logic [15:0]  cjUsed;    // CJ in use
    logic [18:0]  acc;       // Averaging accumulator
    logic [3:0]   accCnt;    // Readings accumulated
    logic [15:0]  aData;     // Analog output
    logic         aValid;    // Analog strobe
    logic         busy;      // Scan slot running
    logic [6:0]   ticks;     // Ticks left in slot
    logic         power;     // Channel power
    logic         acq;       // Acquire pulse
    logic [15:0]  dData;     // Digital output
  } fcd_state_t;

  fcd_state_t s_r;           // Registered state
  fcd_state_t s_nxt;         // Next state
  logic       tick;          // 500 us enable

  // Slot timebase restarts with each slot
  fcd_tick_div u_div (
    .clk_sys (clk_sys),
    .rst     (rst),
    .clr     (scanStart && !s_r.busy),
    .tick    (tick)
  );

  // Classify a sensor code
  function automatic fcd_class_t classify(input logic [5:0] c);
    if (c == SENS_MV1 || c == SENS_MV2)
      classify = CLS_MV;
    else if (c == SENS_OHM)
      classify = CLS_OHM;
    else if (c >= SENS_TC_LO && c <= SENS_TC_HI)
      classify = CLS_TC;
    else if (c >= SENS_RTD_LO && c <= SENS_RTD_HI)
      classify = CLS_RTD;
    else if (c == SENS_COMP)
      classify = CLS_COMP;
    else
      classify = CLS_OFF;
  endfunction

  // Analog word decode; reserved bits never read
  function automatic fcd_analog_t dec_analog(input logic [15:0] w);
    fcd_analog_t a;
    logic [2:0]  m;
    a          = '0;
    m          = w[AMODE_LSB +: AMODE_W];
    a.sensCode = w[ASENS_LSB +: ASENS_W];
    a.sensClass = classify(a.sensCode);
    if (a.sensClass == CLS_MV || a.sensClass == CLS_TC) begin
      a.cjFixed = m[CJ_FIXED_BIT];
      a.burnout = m[1:0];
    end
    // Compensator is resistive as well, so it takes the wiring mode too
    if (a.sensClass == CLS_OHM || a.sensClass == CLS_RTD ||
        a.sensClass == CLS_COMP)
      a.wire4 = (m == WIRE4_MODE);
    a.avgDepth = 4'h1 << w[AFILT_LSB +: AFILT_W];
    return a;
  endfunction

  // Digital word decode; reserved bits never read
  function automatic fcd_digital_t dec_digital(input logic [15:0] w);
    fcd_digital_t d;
    logic [1:0]   m;
    m           = w[DMODE_LSB +: DMODE_W];
    d.active    = (m == DM_ACT || m == DM_ACT_LF);
    d.lineFault = (m == DM_ACT_LF);
    d.powerTicks = d.active ?
      scan_ticks(w[DSCAN_LSB +: DSCAN_W]) :
      DISABLED_TICKS;
    return d;
  endfunction

  // Next-state logic
  always_comb begin
    logic [18:0] sum;
    logic [15:0] avg;
    sum          = '0;
    avg          = '0;
    s_nxt        = s_r;
    s_nxt.aValid = 1'b0;
    s_nxt.acq    = 1'b0;

    // Config writes; words stored as given, decode masks reserved bits
    if (cfgWrA) begin
      s_nxt.cfgA   = cfgWdata;
      s_nxt.acc    = '0;                 // New setting restarts average
      s_nxt.accCnt = '0;
    end
    if (cfgWrD)
      s_nxt.cfgD = cfgWdata;
    s_nxt.ana = dec_analog(s_nxt.cfgA);
    s_nxt.dig = dec_digital(s_nxt.cfgD);

    // Cold-junction source
    s_nxt.cjUsed = s_r.ana.cjFixed ? cjRefTenths : cjAutoTenths;

    // Analog reading path, only for a live channel
    if (sampleIn.valid && !cfgWrA && s_r.ana.sensClass != CLS_OFF) begin
      if (s_r.ana.burnout == BO_CODED &&
          (s_r.ana.sensClass == CLS_MV ||
           s_r.ana.sensClass == CLS_TC)) begin
        // Special codes override the value
        s_nxt.aValid = 1'b1;
        if (sampleIn.boComp)
          s_nxt.aData = CODE_BO_COMP;
        else if (sampleIn.boSens)
          s_nxt.aData = CODE_BO_SENS;
        else if (sampleIn.over)
          s_nxt.aData = CODE_OVER;
        else if (sampleIn.under)
          s_nxt.aData = CODE_UNDER;
        else
          s_nxt.aValid = 1'b0;
      end
      if (!s_nxt.aValid) begin
        if ((sampleIn.boSens || sampleIn.boComp) &&
            s_r.ana.burnout == BO_DOWN) begin
          s_nxt.aData  = rangeLo - 16'h0001;
          s_nxt.aValid = 1'b1;
        end else if ((sampleIn.boSens || sampleIn.boComp) &&
                     s_r.ana.burnout == BO_UP) begin
          s_nxt.aData  = rangeHi + 16'h0001;
          s_nxt.aValid = 1'b1;
        end else if (sampleIn.under) begin
          s_nxt.aData  = rangeLo - 16'h0001;
          s_nxt.aValid = 1'b1;
        end else if (sampleIn.over) begin
          s_nxt.aData  = rangeHi + 16'h0001;
          s_nxt.aValid = 1'b1;
        end else begin
          // Plain average; depth is a power of two so a shift divides
          sum = s_r.acc + {3'h0, sampleIn.value};
          if (s_r.accCnt + 4'h1 >= s_r.ana.avgDepth) begin
            case (s_r.ana.avgDepth)
              4'h2:    avg = sum[16:1];
              4'h4:    avg = sum[17:2];
              4'h8:    avg = sum[18:3];
              default: avg = sum[15:0];
            endcase
            s_nxt.aData  = avg;
            s_nxt.aValid = 1'b1;
            s_nxt.acc    = '0;
            s_nxt.accCnt = '0;
          end else begin
            s_nxt.acc    = sum;
            s_nxt.accCnt = s_r.accCnt + 4'h1;
          end
        end
      end
    end
    if (s_r.ana.sensClass == CLS_OFF)
      s_nxt.aData = '0;                  // Off channel reads zero

    // Digital scan slot: power, wait, acquire
    if (!s_r.busy) begin
      if (scanStart) begin
        s_nxt.busy  = 1'b1;
        s_nxt.ticks = s_r.dig.powerTicks;
        s_nxt.power = s_r.dig.active;
      end
    end else if (tick) begin
      if (s_r.ticks <= 7'h01) begin
        s_nxt.busy  = 1'b0;
        s_nxt.ticks = '0;
        s_nxt.power = 1'b0;
        s_nxt.acq   = s_r.dig.active;
        // Without line-fault detection the status byte is cleared
        s_nxt.dData = s_r.dig.active ?
          (s_r.dig.lineFault ? digInputs : {8'h00, digInputs[7:0]}) :
          16'h0000;
      end else begin
        s_nxt.ticks = s_r.ticks - 7'h01;
      end
    end
    if (!s_r.dig.active)
      s_nxt.dData = '0;
  end

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_r      <= '0;
      s_r.cfgA <= CFG_RESET;
      s_r.cfgD <= CFG_RESET;
      s_r.dig.powerTicks <= DISABLED_TICKS;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from flops
  assign cfgRdA       = s_r.cfgA;
  assign cfgRdD       = s_r.cfgD;
  assign analogCfg    = s_r.ana;
  assign digitalCfg   = s_r.dig;
  assign cjUsedTenths = s_r.cjUsed;
  assign analogData   = s_r.aData;
  assign analogValid  = s_r.aValid;
  assign chanPower    = s_r.power;
  assign acquire      = s_r.acq;
  assign digitalData  = s_r.dData;
endmodule

// ---- verif/fcd_decoder_sva.sv ----
// Checker of decode and result shaping at the decoder ports
`timescale 1ns/100ps
module fcd_decoder_sva
  import fcd_pkg::*;
(
  input wire logic         clk_sys,     // System clock
  input wire logic         rst,         // Sync reset
  input wire logic         cfgWrA,      // Analog write
  input wire logic         cfgWrD,      // Digital write
  input wire logic [15:0]  cfgWdata,    // Written word
  input wire fcd_sample_t  sampleIn,    // Converter reading
  input wire fcd_analog_t  analogCfg,   // Analog decode
  input wire fcd_digital_t digitalCfg,  // Digital decode
  input wire logic [15:0]  analogData,  // Analog result
  input wire logic         analogValid, // Result strobe
  input wire logic         chanPower,   // Slot power
  input wire logic         acquire,     // Acquire pulse
  input wire logic [15:0]  digitalData  // Digital result
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Word as taken, decode shows one edge later
  logic [15:0] wPrev;
  always_ff @(posedge clk_sys) wPrev <= cfgWdata;
  // Sensor groups whose mode means burnout or wiring
  wire logic mvTc = cfgWdata[5:0] inside {[1:2], [4:18]};
  wire logic rtd  = cfgWdata[5:0] inside {3, [19:30]};
  // Compensator burnout taken in coded mode
  sequence s_codedComp;
    sampleIn.valid && sampleIn.boComp && !cfgWrA &&
      analogCfg.burnout == BO_CODED &&
      analogCfg.sensClass inside {CLS_MV, CLS_TC};
  endsequence
  sens_field_a: assert property (
    cfgWrA |=> analogCfg.sensCode == wPrev[5:0])
    else $error("sensor code field wrong");
  mode_field_a: assert property (
    cfgWrA && mvTc |=> analogCfg.cjFixed == wPrev[9] &&
      analogCfg.burnout == wPrev[8:7])
    else $error("mode field wrong");
  filt_depth_a: assert property (
    cfgWrA |=> analogCfg.avgDepth == (4'h1 << wPrev[12:11]))
    else $error("filter depth wrong");
  wire_mode_a: assert property (
    cfgWrA && rtd |=> analogCfg.wire4 == (wPrev[9:7] == 3'h1))
    else $error("wiring mode wrong");
  dig_mode_a: assert property (
    cfgWrD |=> digitalCfg.active == wPrev[0] &&
      digitalCfg.lineFault == &wPrev[1:0])
    else $error("digital mode wrong");
  off_slot_a: assert property (
    cfgWrD && !cfgWdata[0] |=> digitalCfg.powerTicks == 7'h01)
    else $error("disabled slot length wrong");
  coded_comp_a: assert property (
    s_codedComp |=> analogValid && analogData == 16'h7d03)
    else $error("coded compensator value wrong");
  dig_off_a: assert property (
    !digitalCfg.active [*2] |->
      digitalData == 16'h0000 && !chanPower && !acquire)
    else $error("inactive digital channel not quiet");
  ana_off_a: assert property (
    (analogCfg.sensClass == CLS_OFF) [*2] |->
      analogData == 16'h0000 && !analogValid)
    else $error("analog channel off not quiet");
  acq_end_a: assert property (
    acquire |-> !chanPower && $past(chanPower))
    else $error("acquire not at end of power");
endmodule

bind fcd_channel_decoder fcd_decoder_sva i_sva (
  .clk_sys(clk_sys), .rst(rst), .cfgWrA(cfgWrA), .cfgWrD(cfgWrD),
  .cfgWdata(cfgWdata), .sampleIn(sampleIn), .analogCfg(analogCfg),
  .digitalCfg(digitalCfg), .analogData(analogData),
  .analogValid(analogValid), .chanPower(chanPower), .acquire(acquire),
  .digitalData(digitalData));

// ---- verif/fcd_field_model.sv ----
// Field side model: converter readings and discrete input lines
`timescale 1ns/100ps
module fcd_field_model
  import fcd_pkg::*;
(
  input  wire logic        clk_sys,   // System clock
  input  wire logic        chanPower, // Lines powered
  input  wire logic [15:0] lineWord,  // Switch states when powered
  output fcd_sample_t      sampleIn,  // Converter reading
  output logic [15:0]      digInputs  // Discrete input word
);
  logic [15:0] junk = 16'h5a5a; // Unpowered lines float
  // Toggle so a stale word never passes for a live one
  always @(posedge clk_sys) junk <= ~junk;
  assign digInputs = chanPower ? lineWord : junk;
  initial sampleIn = '0;
  // One strobe; value lines scrambled once it drops
  // Idle cycle after the strobe so back-to-back calls never collide
  task automatic read(input logic [15:0] v, input logic [3:0] f);
    sampleIn = {1'b1, v, f};
    @(negedge clk_sys);
    sampleIn = {1'b0, ~v, 4'h0};
    @(negedge clk_sys);
  endtask
endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the channel config decoder
`timescale 1ns/100ps
module tb
  import fcd_pkg::*;
;
  logic clk_sys = 0, rst = 1, cfgWrA = 0, cfgWrD = 0, scanStart = 0;
  logic [15:0] cfgWdata = 0, cjRefTenths, cjAutoTenths, rangeLo, rangeHi;
  logic [15:0] lineWord, cfgRdA, cfgRdD, cjUsedTenths, analogData;
  logic [15:0] digitalData, digInputs;
  logic analogValid, chanPower, acquire;
  fcd_sample_t  sampleIn;
  fcd_analog_t  analogCfg;
  fcd_digital_t digitalCfg;
  int n_mismatch = 0, checks_done = 0, seed = 50199;
  logic [15:0] qa[$], qd[$]; // Expected results, oldest first
  int ms[16] = '{1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 16, 18, 20, 25, 30, 35};

  fcd_channel_decoder i_fcd_channel_decoder (.clk_sys, .rst, .cfgWrA,
    .cfgWrD, .cfgWdata, .cjRefTenths, .cjAutoTenths, .rangeLo, .rangeHi,
    .sampleIn, .digInputs, .scanStart, .cfgRdA, .cfgRdD, .analogCfg,
    .digitalCfg, .cjUsedTenths, .analogData, .analogValid, .chanPower,
    .acquire, .digitalData);
  fcd_field_model i_fcd_field_model (.clk_sys, .chanPower, .lineWord,
    .sampleIn, .digInputs);

  initial forever #20 clk_sys = ~clk_sys;

  task automatic chk(input string nm, input logic [15:0] e, s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude;
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Config write, one cycle strobe, then one idle cycle
  task automatic wr(input logic d, input logic [15:0] w);
    cfgWdata = w;
    cfgWrA = !d;
    cfgWrD = d;
    @(negedge clk_sys);
    cfgWrA = 0;
    cfgWrD = 0;
    @(negedge clk_sys);
  endtask
  task automatic pulse;
    scanStart = 1;
    @(negedge clk_sys);
    scanStart = 0;
  endtask
  // Bounded wait for all expected results
  task automatic settle;
    for (int k = 0; k < 20 && (qa.size() || qd.size()); k++)
      @(negedge clk_sys);
    if (qa.size() || qd.size()) begin
      n_mismatch++;
      conclude();
    end
  endtask
  function automatic fcd_class_t cls(input int c);
    if (c inside {1, 2}) return CLS_MV;
    if (c == 3) return CLS_OHM;
    if (c inside {[4:18]}) return CLS_TC;
    if (c inside {[19:29]}) return CLS_RTD;
    return (c == 30) ? CLS_COMP : CLS_OFF;
  endfunction
  // Shaped result; f is under, over, sensor and compensator burnout
  function automatic logic [15:0] expA(input logic [1:0] b,
      input logic [3:0] f, input logic [15:0] v);
    if (b == 2'h3)
      return f[0] ? 16'h7d03 : f[1] ? 16'h7d02 : f[2] ? 16'h7d01 :
        f[3] ? 16'h7d00 : v;
    if ((f[0] | f[1]) && b != 2'h0)
      return b[0] ? rangeLo - 16'h1 : rangeHi + 16'h1;
    if (f[3]) return rangeLo - 16'h1;
    return f[2] ? rangeHi + 16'h1 : v;
  endfunction

  // Each result strobe takes the oldest expectation
  always @(negedge clk_sys) begin
    if (analogValid === 1'b1)
      chk("analogData", qa.size() ? qa.pop_front() : 'x, analogData);
    if (acquire === 1'b1)
      chk("digitalData", qd.size() ? qd.pop_front() : 'x, digitalData);
  end

  initial begin
    logic [15:0] w, s;
    int n;
    cjRefTenths = 16'($random(seed));
    cjAutoTenths = 16'($random(seed));
    rangeLo = 16'($random(seed));
    rangeHi = 16'($random(seed));
    lineWord = 16'($random(seed));
    repeat (12) @(negedge clk_sys);
    // Reset state: analog word cleared, disabled slot length
    chk("rstCfgRdA", 16'h0000, cfgRdA);
    chk("rstPowerTicks", 16'h0001, 16'(digitalCfg.powerTicks));
    rst = 0;
    // Every sensor code, reserved bits random
    for (int c = 0; c < 64; c++) begin
      w = 16'($random(seed));
      w[5:0] = 6'(c);
      wr(0, w);
      chk("cfgRdA", w, cfgRdA);
      chk("sensClass", 16'(cls(c)), 16'(analogCfg.sensClass));
      chk("avgDepth", 16'h1 << w[12:11], 16'(analogCfg.avgDepth));
    end
    // Every scan code with random mode
    for (int t = 0; t < 16; t++) begin
      w = 16'($random(seed));
      w[6:3] = 4'(t);
      wr(1, w);
      chk("cfgRdD", w, cfgRdD);
      chk("active", 16'(w[0]), 16'(digitalCfg.active));
      s = w[0] ? 16'(2 * ms[t]) : 16'h1;
      chk("powerTicks", s, 16'(digitalCfg.powerTicks));
    end
    // Thermocouple, all modes, each fault flag alone
    for (int m = 0; m < 8; m++) begin
      wr(0, 16'(128 * m + 7));
      for (int k = 0; k < 4; k++) begin
        s = 16'($random(seed));
        qa.push_back(expA(2'(m), 4'h1 << k, s));
        i_fcd_field_model.read(s, 4'h1 << k);
      end
      s = m[2] ? cjRefTenths : cjAutoTenths;
      chk("cjUsed", s, cjUsedTenths);
    end
    // Averaging depths 2, 4, 8 on millivolt input
    for (int f = 1; f < 4; f++) begin
      wr(0, 16'(2048 * f + 1));
      n = 0;
      for (int k = 0; k < (1 << f); k++) begin
        s = 16'($random(seed)) & 16'h0fff;
        n += s;
        if (k == (1 << f) - 1) qa.push_back(16'(n >> f));
        i_fcd_field_model.read(s, 4'h0);
      end
    end
    settle();
    // Disabled slot: half a millisecond, nothing powered
    wr(1, 16'h0000);
    pulse();
    repeat (12600) @(negedge clk_sys);
    // Fastest scan code, with and without fault bits
    for (int j = 0; j < 2; j++) begin
      lineWord = 16'($random(seed));
      wr(1, j ? 16'h0001 : 16'h0003);
      qd.push_back(j ? {8'h00, lineWord[7:0]} : lineWord);
      pulse();
      n = 0;
      for (int k = 0; k < 30000 && !acquire; k++) begin
        n += chanPower;
        @(negedge clk_sys);
      end
      if (!acquire) begin
        n_mismatch++;
        conclude();
      end
      chk("powerTime", 16'h00fa, 16'((n + 50) / 100));
    end
    settle();
    conclude();
  end
endmodule
